//--- verilog/spfs_pkg.sv
package spfs_pkg;

  // ==================================================
  // Register map (word aligned byte addresses)
  // ==================================================
  localparam logic [4:0] PTR_LOW_OFS = 5'h00;
  localparam logic [4:0] PTR_HIGH_OFS = 5'h04;
  localparam logic [4:0] PTR_UPPER_OFS = 5'h08;
  localparam logic [4:0] LATCH_OFS = 5'h0C;
  localparam logic [4:0] CTRL_OFS = 5'h10;
  localparam logic [4:0] UNLOCK_OFS = 5'h14;
  localparam logic [4:0] TABLE_OP_OFS = 5'h18;
  localparam logic [4:0] STATUS_OFS = 5'h1C;

  // ==================================================
  // Control register fields
  // ==================================================
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int CTRL_ERASE_BIT = 4;
  localparam int CTRL_CFG_BIT = 6;
  localparam int CTRL_PGM_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Table operation command: bit 0 write, bits 2:1 pointer update
  localparam int OP_WRITE_BIT = 0;
  localparam logic [1:0] PTR_KEEP = 2'h0;
  localparam logic [1:0] PTR_POST_INC = 2'h1;
  localparam logic [1:0] PTR_POST_DEC = 2'h2;
  localparam logic [1:0] PTR_PRE_INC = 2'h3;

  // ==================================================
  // Unlock, holding and timing constants
  // ==================================================
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] HOLD_RESET = 8'hFF;
  localparam int HOLD_COUNT = 8;
  localparam int ROW_BYTES = 64;
  localparam int PTR_WIDTH = 22;
  localparam int CLK_HZ = 25_000_000;
  localparam int LONG_WRITE_US = 2000;
  localparam int LONG_WRITE_CYCLES = (CLK_HZ / 1_000_000) * LONG_WRITE_US;

  typedef enum logic [1:0] {
    SPFS_ST_IDLE,
    SPFS_ST_ERASE,
    SPFS_ST_PROGRAM
  } spfs_state_t;

  // Flash array port bundle
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic [PTR_WIDTH-1:0] addr;
    logic [7:0] wdata;
  } spfs_flash_req_t;

endpackage : spfs_pkg

//--- verilog/spfs_hold_regs.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_hold_regs #(
  parameter int DEPTH = spfs_pkg::HOLD_COUNT
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Load and restore
  input wire logic load_in,
  input wire logic [$clog2(DEPTH)-1:0] index_in,
  input wire logic [7:0] data_in,
  input wire logic restore_in,
  // Contents
  output logic [DEPTH*8-1:0] bytes_out
);

  // ==================================================
  // Holding bytes
  // ==================================================
  initial begin
    if (DEPTH < 2) $error("hold depth too small");
  end

  localparam int IW = $clog2(DEPTH);
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_hold
      logic [7:0] byte_ff;
      wire logic hit = load_in && (index_in == IW'(gi));
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          byte_ff <= spfs_pkg::HOLD_RESET; // see [R18]
        end else if (ce_in) begin
          if (restore_in) begin
            byte_ff <= spfs_pkg::HOLD_RESET; // see [R18]
          end else if (hit) begin
            byte_ff <= data_in; // see [R14]
          end
        end
      end
      assign bytes_out[gi*8 +: 8] = byte_ff;
    end
  endgenerate

endmodule : spfs_hold_regs
`default_nettype wire

//--- verilog/spfs_timer.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_timer #(
  parameter int CYCLES = spfs_pkg::LONG_WRITE_CYCLES
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Start and expiry
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  // ==================================================
  // Programming timer
  // ==================================================
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  initial begin
    if (CYCLES < 2) $error("timer too short");
  end

  wire logic last = busy_ff && (cnt_ff == CW'(1));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce_in) begin
      done_ff <= last;
      if (start_in && !busy_ff) begin
        cnt_ff <= CW'(CYCLES);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - CW'(1);
        busy_ff <= !last;
      end
    end
  end

  assign busy_out = busy_ff;
  assign done_out = done_ff;

endmodule : spfs_timer
`default_nettype wire

//--- verilog/spfs_sequencer.sv
// Summary of operation
// [R1] One program byte per table read
// [R2] Table read copies addressed byte into latch
// [R3] Table read may step the pointer
// [R4] Pointer bit zero picks high/low byte
// [R5] Erase clears one whole 64-byte row
// [R6] Erase row from pointer bits 21:6
// [R7] Software sets program, permit, erase bits
// [R8] Software clears config-space select first
// [R9] Software loads pointer before erase setup
// [R10] Unlock 55h then AAh before go
// [R11] Go starts timed 2 ms erase
// [R12] Long write stalls instruction execution
// [R13] Programming acts on 8-byte blocks
// [R14] Eight byte-wide holding registers
// [R15] Table write only loads holding register
// [R16] Control write launches holding-to-flash program
// [R17] Program duration set by internal timer
// [R18] Holding registers FFh after reset/program
// [R19] FFh byte unchanged, only clears bits
// [R20] Partly loaded holding set still programs
// [R21] Pointer 2:0 picks holder, 21:3 block
// [R22] Go set by software, cleared by hardware
// [R23] Erase enable cleared when erase ends
// [R24] Completion flag set by hardware only
// [R25] Software masks interrupts around unlock
// [R26] Go ignored without unlock or permit
`timescale 1ns/1ps
`default_nettype none
module spfs_sequencer #(
  parameter int LONG_CYCLES = spfs_pkg::LONG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  // Flash array port
  output spfs_pkg::spfs_flash_req_t flash_req_out,
  output logic [63:0] flash_block_out,
  input wire logic [15:0] flash_rword_in,
  // Core status
  output logic core_stall_out,
  output logic nvm_done_irq_flag_out,
  input wire logic nvm_done_irq_clear_in
);

  // ==================================================
  // State
  // ==================================================
  localparam int PW = spfs_pkg::PTR_WIDTH;
  spfs_pkg::spfs_state_t state_ff, nxt_state;
  logic [PW-1:0] table_pointer_ff, nxt_table_pointer;
  logic [7:0] table_latch_ff;
  logic [7:0] memory_control_reg_ff, nxt_ctrl;
  logic [1:0] unlock_ff, nxt_unlock;
  logic ack_ff;
  logic wait_ff;
  logic stall_ff;
  logic [31:0] rdata_ff;
  logic [1:0] resp_ff;
  logic irq_ff;
  logic rd_pend_ff;
  spfs_pkg::spfs_flash_req_t freq_ff, nxt_freq;
  logic [63:0] fblock_ff;
  logic [63:0] hold_bytes;
  logic tmr_busy, tmr_done;

  // ==================================================
  // Bus decode
  // ==================================================
  wire logic req = (avs_read_in || avs_write_in) && !ack_ff;
  wire logic idle = (state_ff == spfs_pkg::SPFS_ST_IDLE);
  // Table reads need a flash turn-round, so hold them until data is back
  wire logic is_op = (avs_address_in == spfs_pkg::TABLE_OP_OFS);
  wire logic op_wr = avs_writedata_in[spfs_pkg::OP_WRITE_BIT];
  wire logic [1:0] op_mode = avs_writedata_in[2:1];
  // Bus requests wait out a long write, which stalls the core too
  wire logic accept = req && idle && !(is_op && avs_write_in && !op_wr && !rd_pend_ff); // see [R12]
  // First cycle of a table read: pulse the flash read, answer on the next
  wire logic rd_start = req && is_op && avs_write_in && !op_wr && idle && !rd_pend_ff;
  wire logic wr = accept && avs_write_in && avs_byteenable_in[0];
  wire logic wr_ptr_l = wr && (avs_address_in == spfs_pkg::PTR_LOW_OFS);
  wire logic wr_ptr_h = wr && (avs_address_in == spfs_pkg::PTR_HIGH_OFS);
  wire logic wr_ptr_u = wr && (avs_address_in == spfs_pkg::PTR_UPPER_OFS);
  wire logic wr_latch = wr && (avs_address_in == spfs_pkg::LATCH_OFS);
  wire logic wr_ctrl = wr && (avs_address_in == spfs_pkg::CTRL_OFS);
  wire logic wr_unlock = wr && (avs_address_in == spfs_pkg::UNLOCK_OFS);
  wire logic wr_op = wr && is_op;
  wire logic mapped = (avs_address_in[1:0] == 2'h0);
  wire logic [7:0] wbyte = avs_writedata_in[7:0];

  // Table op: reads pre-increment first, then act, then post-step; writes act at the unstepped pointer
  wire logic [PW-1:0] ptr_inc = table_pointer_ff + PW'(1);
  wire logic [PW-1:0] ptr_dec = table_pointer_ff - PW'(1);
  wire logic [PW-1:0] op_addr = (op_mode == spfs_pkg::PTR_PRE_INC) ? ptr_inc : table_pointer_ff;
  wire logic [PW-1:0] ptr_after = (op_mode == spfs_pkg::PTR_POST_INC) ? ptr_inc :
                                  (op_mode == spfs_pkg::PTR_POST_DEC) ? ptr_dec :
                                  (op_mode == spfs_pkg::PTR_PRE_INC) ? ptr_inc : table_pointer_ff; // see [R3]

  // Only the low 21 pointer bits step; bit 21 stays put
  wire logic [PW-1:0] ptr_stepped = {table_pointer_ff[PW-1], ptr_after[PW-2:0]};

  // ==================================================
  // Go qualification
  // ==================================================
  wire logic go_req = wr_ctrl && wbyte[spfs_pkg::CTRL_GO_BIT] && !memory_control_reg_ff[spfs_pkg::CTRL_GO_BIT];
  wire logic go_ok = go_req && (unlock_ff == 2'h2)
                     && memory_control_reg_ff[spfs_pkg::CTRL_PERMIT_BIT]; // see [R10] see [R26]
  wire logic go_bad = go_req && !go_ok;
  wire logic do_erase = go_ok && wbyte[spfs_pkg::CTRL_ERASE_BIT];
  wire logic do_prog = go_ok && !wbyte[spfs_pkg::CTRL_ERASE_BIT];

  // Any bus access other than the second key breaks the unlock chain
  always_comb begin
    nxt_unlock = unlock_ff;
    if (accept) begin
      nxt_unlock = 2'h0;
      if (wr_unlock && wbyte == spfs_pkg::UNLOCK_KEY1) begin
        nxt_unlock = 2'h1;
      end else if (wr_unlock && wbyte == spfs_pkg::UNLOCK_KEY2 && unlock_ff == 2'h1) begin
        nxt_unlock = 2'h2; // see [R10]
      end
    end
  end

  // ==================================================
  // Control register and long write state
  // ==================================================
  always_comb begin
    nxt_ctrl = memory_control_reg_ff;
    nxt_state = state_ff;
    if (wr_ctrl) begin
      nxt_ctrl[spfs_pkg::CTRL_PGM_BIT] = wbyte[spfs_pkg::CTRL_PGM_BIT];
      nxt_ctrl[spfs_pkg::CTRL_CFG_BIT] = wbyte[spfs_pkg::CTRL_CFG_BIT];
      nxt_ctrl[spfs_pkg::CTRL_ERASE_BIT] = wbyte[spfs_pkg::CTRL_ERASE_BIT];
      nxt_ctrl[spfs_pkg::CTRL_ABORT_BIT] = wbyte[spfs_pkg::CTRL_ABORT_BIT] | go_bad;
      nxt_ctrl[spfs_pkg::CTRL_PERMIT_BIT] = wbyte[spfs_pkg::CTRL_PERMIT_BIT];
    end
    if (go_ok) begin
      nxt_ctrl[spfs_pkg::CTRL_GO_BIT] = 1'b1; // see [R22]
      nxt_ctrl[spfs_pkg::CTRL_ABORT_BIT] = 1'b1;
    end
    case (state_ff)
      spfs_pkg::SPFS_ST_IDLE: begin
        if (do_erase) begin
          nxt_state = spfs_pkg::SPFS_ST_ERASE; // see [R11]
        end else if (do_prog) begin
          nxt_state = spfs_pkg::SPFS_ST_PROGRAM; // see [R16]
        end
      end
      spfs_pkg::SPFS_ST_ERASE, spfs_pkg::SPFS_ST_PROGRAM: begin
        if (tmr_done) begin
          nxt_state = spfs_pkg::SPFS_ST_IDLE; // see [R11] see [R17]
          nxt_ctrl[spfs_pkg::CTRL_GO_BIT] = 1'b0; // see [R22]
          nxt_ctrl[spfs_pkg::CTRL_ABORT_BIT] = 1'b0;
          if (state_ff == spfs_pkg::SPFS_ST_ERASE) begin
            nxt_ctrl[spfs_pkg::CTRL_ERASE_BIT] = 1'b0; // see [R23]
          end
        end
      end
      default: begin
        nxt_state = spfs_pkg::SPFS_ST_IDLE;
      end
    endcase
  end

  // ==================================================
  // Pointer and flash request
  // ==================================================
  always_comb begin
    nxt_table_pointer = table_pointer_ff;
    if (wr_ptr_l) begin
      nxt_table_pointer[7:0] = wbyte;
    end
    if (wr_ptr_h) begin
      nxt_table_pointer[15:8] = wbyte;
    end
    if (wr_ptr_u) begin
      nxt_table_pointer[PW-1:16] = wbyte[PW-17:0];
    end
    if (wr_op && (op_wr || rd_pend_ff)) begin
      nxt_table_pointer = ptr_stepped; // see [R3]
    end
  end

  always_comb begin
    nxt_freq = '0;
    nxt_freq.addr = freq_ff.addr;
    if (rd_start) begin
      nxt_freq.rd = 1'b1; // see [R1]
      nxt_freq.addr = op_addr;
    end else if (do_erase) begin
      nxt_freq.erase = 1'b1;
      nxt_freq.addr = {table_pointer_ff[PW-1:6], 6'h00}; // see [R5] see [R6]
    end else if (do_prog) begin
      nxt_freq.prog = 1'b1;
      nxt_freq.addr = {table_pointer_ff[PW-1:3], 3'h0}; // see [R13] see [R21]
    end
  end

  // Read data: low byte on even address, high byte on odd
  wire logic [7:0] rd_byte = freq_ff.addr[0] ? flash_rword_in[15:8] : flash_rword_in[7:0]; // see [R4]
  wire logic rd_take = accept && avs_write_in && is_op && !op_wr; // see [R2]
  wire logic hold_load = wr_op && op_wr; // see [R15] see [R21]

  // ==================================================
  // Read mux
  // ==================================================
  wire logic [31:0] rmux =
    (avs_address_in == spfs_pkg::PTR_LOW_OFS) ? {24'h000000, table_pointer_ff[7:0]} :
    (avs_address_in == spfs_pkg::PTR_HIGH_OFS) ? {24'h000000, table_pointer_ff[15:8]} :
    (avs_address_in == spfs_pkg::PTR_UPPER_OFS) ? {26'h0000000, table_pointer_ff[PW-1:16]} :
    (avs_address_in == spfs_pkg::LATCH_OFS) ? {24'h000000, table_latch_ff} :
    (avs_address_in == spfs_pkg::CTRL_OFS) ? {24'h000000, memory_control_reg_ff & 8'hDE} :
    (avs_address_in == spfs_pkg::STATUS_OFS) ? {30'h00000000, irq_ff, !idle} : 32'h00000000;

  // ==================================================
  // Registers
  // ==================================================
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= spfs_pkg::SPFS_ST_IDLE;
      table_pointer_ff <= '0;
      table_latch_ff <= 8'h00;
      memory_control_reg_ff <= spfs_pkg::CTRL_RESET;
      unlock_ff <= 2'h0;
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      stall_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      resp_ff <= 2'h0;
      irq_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      freq_ff <= '0;
      fblock_ff <= '0;
    end else if (ce_in) begin
      state_ff <= nxt_state;
      table_pointer_ff <= nxt_table_pointer;
      memory_control_reg_ff <= nxt_ctrl;
      unlock_ff <= nxt_unlock;
      freq_ff <= nxt_freq;
      ack_ff <= accept;
      wait_ff <= !accept;
      stall_ff <= (nxt_state != spfs_pkg::SPFS_ST_IDLE); // see [R12]
      resp_ff <= mapped ? 2'h0 : 2'h2;
      rdata_ff <= rmux;
      rd_pend_ff <= rd_start;
      if (wr_latch) begin
        table_latch_ff <= wbyte;
      end else if (rd_take) begin
        table_latch_ff <= rd_byte; // see [R2]
      end
      if (do_prog) begin
        fblock_ff <= hold_bytes; // see [R19] see [R20]
      end
      if (tmr_done) begin
        irq_ff <= 1'b1; // see [R24]
      end else if (nvm_done_irq_clear_in) begin
        irq_ff <= 1'b0;
      end
    end
  end

  // ==================================================
  // Submodules
  // ==================================================
  spfs_hold_regs #(
    .DEPTH(spfs_pkg::HOLD_COUNT)
  ) u_hold (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .load_in(hold_load),
    .index_in(table_pointer_ff[2:0]), // see [R21]
    .data_in(table_latch_ff),
    .restore_in(do_prog), // see [R18]
    .bytes_out(hold_bytes)
  );

  spfs_timer #(
    .CYCLES(LONG_CYCLES)
  ) u_timer (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .start_in(go_ok),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // ==================================================
  // Outputs
  // ==================================================
  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign avs_response_out = resp_ff;
  assign flash_req_out = freq_ff;
  assign flash_block_out = fblock_ff;
  assign core_stall_out = stall_ff; // see [R12]
  assign nvm_done_irq_flag_out = irq_ff;

endmodule : spfs_sequencer
`default_nettype wire

//--- bench/spfs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_sequencer_asserts #(
  parameter int LONG_CYCLES = 20
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [1:0] avs_response_out,
  // Flash and core
  input wire spfs_pkg::spfs_flash_req_t flash_req_out,
  input wire logic [63:0] flash_block_out,
  input wire logic [15:0] flash_rword_in,
  input wire logic core_stall_out,
  input wire logic nvm_done_irq_flag_out,
  input wire logic nvm_done_irq_clear_in
);
  // ==========
  // Checks
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] stall_cnt_ff;
  logic [15:0] nxt_stall_cnt;
  // A repetition cannot span a long write, so its length is counted
  assign nxt_stall_cnt = core_stall_out ? stall_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stall_cnt_ff <= 16'h0000;
    end else begin
      stall_cnt_ff <= nxt_stall_cnt;
    end
  end
  sequence s_launch;
    flash_req_out.erase || flash_req_out.prog;
  endsequence
  sequence s_end;
    core_stall_out ##1 !core_stall_out;
  endsequence
  property p_launch;
    s_launch |-> core_stall_out ##1 core_stall_out;
  endproperty
  a_launch: assert property (p_launch) else $error("launch without stall");
  property p_rise;
    $rose(core_stall_out) |-> s_launch;
  endproperty
  a_rise: assert property (p_rise) else $error("stall without launch");
  property p_len;
    s_end |-> stall_cnt_ff >= LONG_CYCLES && stall_cnt_ff <= LONG_CYCLES + 1;
  endproperty
  a_len: assert property (p_len) else $error("long write length wrong");
  property p_wait;
    core_stall_out && $past(core_stall_out) |-> avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("access answered in long write");
  property p_hold;
    nvm_done_irq_flag_out && !nvm_done_irq_clear_in |=> nvm_done_irq_flag_out;
  endproperty
  a_hold: assert property (p_hold) else $error("done flag dropped by itself");
  property p_src;
    s_end |-> ##[0:1] nvm_done_irq_flag_out;
  endproperty
  a_src: assert property (p_src) else $error("done flag not set at end");
  property p_rd_ack;
    flash_req_out.rd |=> !avs_waitrequest_out;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("table read not answered");
  property p_short;
    avs_write_in && !avs_waitrequest_out && avs_address_in == spfs_pkg::TABLE_OP_OFS
      && avs_writedata_in[spfs_pkg::OP_WRITE_BIT] |=> !core_stall_out && !flash_req_out.prog;
  endproperty
  a_short: assert property (p_short) else $error("table write became long");
endmodule : spfs_sequencer_asserts
bind spfs_sequencer spfs_sequencer_asserts #(.LONG_CYCLES(LONG_CYCLES)) u_asserts (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
  .flash_req_out(flash_req_out), .flash_block_out(flash_block_out), .flash_rword_in(flash_rword_in),
  .core_stall_out(core_stall_out), .nvm_done_irq_flag_out(nvm_done_irq_flag_out),
  .nvm_done_irq_clear_in(nvm_done_irq_clear_in)
);
`default_nettype wire

//--- bench/spfs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_flash_model (
  // Clock
  input wire logic clk_in,
  // Array port
  input wire spfs_pkg::spfs_flash_req_t req_in,
  input wire logic [63:0] block_in,
  output logic [15:0] rword_out
);
  // ==========
  // Array of 128 words, four rows
  logic [15:0] mem [128];
  logic [15:0] last_ff = 16'h0000;
  logic rd_d_ff = 1'b0;
  logic [6:0] widx;
  assign widx = req_in.addr[7:1];
  // Outside a read the word flips every cycle so a late sample cannot match by luck
  assign rword_out = (req_in.rd || rd_d_ff) ? mem[widx] : ~last_ff;
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = {~i[7:0], i[7:0] ^ 8'h5A};
  end
  always @(posedge clk_in) begin
    rd_d_ff <= req_in.rd;
    last_ff <= rword_out;
    if (req_in.erase) begin
      for (int i = 0; i < 32; i++) mem[{req_in.addr[7:6], i[4:0]}] <= 16'hFFFF;
    end
    if (req_in.prog) begin
      for (int j = 0; j < 4; j++) mem[{req_in.addr[7:3], j[1:0]}] <=
        mem[{req_in.addr[7:3], j[1:0]}] & block_in[16*j +: 16];
    end
  end
endmodule : spfs_flash_model
`default_nettype wire

//--- bench/spfs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spfs_sequencer_tb_top;
  // ==========
  // Harness
  localparam int LONG = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic irq_clr = 1'b0;
  logic [31:0] rdata;
  logic waitreq;
  logic [1:0] resp;
  logic [1:0] resp_q;
  spfs_pkg::spfs_flash_req_t freq;
  logic [63:0] fblock;
  logic [15:0] rword;
  logic stall;
  logic irq;
  logic [15:0] snap [128];
  int failures = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  spfs_sequencer #(.LONG_CYCLES(LONG)) dut (
    .core_clk_in(clk), .reset_in(rst), .ce_in(1'b1), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .avs_response_out(resp), .flash_req_out(freq),
    .flash_block_out(fblock), .flash_rword_in(rword), .core_stall_out(stall),
    .nvm_done_irq_flag_out(irq), .nvm_done_irq_clear_in(irq_clr)
  );
  spfs_flash_model u_flash (.clk_in(clk), .req_in(freq), .block_in(fblock), .rword_out(rword));
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, d};
    rd <= ~we;
    wr <= we;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 2000);
    q = rdata;
    resp_q = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 2000) begin
      failures++;
      $display("BAD waitrequest exp 0 got %b", waitreq);
      summarize();
    end
  endtask : bus
  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrr
  task automatic go(input logic [7:0] c);
    wrr(spfs_pkg::UNLOCK_OFS, spfs_pkg::UNLOCK_KEY1);
    wrr(spfs_pkg::UNLOCK_OFS, spfs_pkg::UNLOCK_KEY2);
    wrr(spfs_pkg::CTRL_OFS, c);
  endtask : go
  task automatic setptr(input logic [21:0] p);
    wrr(spfs_pkg::PTR_LOW_OFS, p[7:0]);
    wrr(spfs_pkg::PTR_HIGH_OFS, p[15:8]);
    wrr(spfs_pkg::PTR_UPPER_OFS, {2'b00, p[21:16]});
  endtask : setptr
  function automatic logic [7:0] fbyte(input logic [21:0] p);
    logic [15:0] w;
    w = u_flash.mem[p[7:1]];
    return p[0] ? w[15:8] : w[7:0];
  endfunction : fbyte
  task automatic wait_done;
    logic [31:0] q;
    int n;
    n = 0;
    while (stall !== 1'b1 && n < 4) begin
      @(posedge clk);
      n++;
    end
    chk("stall", 64'h1, stall);
    bus(1'b0, spfs_pkg::STATUS_OFS, 8'h00, q);
    chk("status", 64'h2, q[1:0]);
    irq_clr <= 1'b1;
    @(posedge clk);
    irq_clr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("done_flag", 64'h0, irq);
  endtask : wait_done
  // ==========
  // Scenarios
  task automatic t_reset;
    logic [31:0] q;
    bus(1'b0, spfs_pkg::CTRL_OFS, 8'h00, q);
    chk("ctrl", spfs_pkg::CTRL_RESET, q);
    bus(1'b0, spfs_pkg::UNLOCK_OFS, 8'h00, q);
    chk("unlock", 64'h0, q);
    bus(1'b0, 5'h01, 8'h00, q);
    chk("response", 64'h2, resp_q);
    $display("test reset done");
  endtask : t_reset
  task automatic t_read;
    logic [31:0] q;
    for (int m = 0; m < 4; m++) begin
      setptr(22'h000021);
      wrr(spfs_pkg::TABLE_OP_OFS, {5'h00, m[1:0], 1'b0});
      bus(1'b0, spfs_pkg::LATCH_OFS, 8'h00, q);
      chk("table_latch", fbyte(m == 3 ? 22'h000022 : 22'h000021), q[7:0]);
      bus(1'b0, spfs_pkg::PTR_LOW_OFS, 8'h00, q);
      chk("ptr_low", m == 0 ? 8'h21 : m == 2 ? 8'h20 : 8'h22, q[7:0]);
    end
    $display("test read done");
  endtask : t_read
  task automatic t_refuse;
    logic [31:0] q;
    for (int v = 0; v < 3; v++) begin
      wrr(spfs_pkg::CTRL_OFS, v == 2 ? 8'h80 : 8'h84);
      if (v > 0) begin
        wrr(spfs_pkg::UNLOCK_OFS, spfs_pkg::UNLOCK_KEY1);
        wrr(spfs_pkg::UNLOCK_OFS, spfs_pkg::UNLOCK_KEY2);
      end
      if (v == 1) wrr(spfs_pkg::PTR_LOW_OFS, 8'h00);
      wrr(spfs_pkg::CTRL_OFS, v == 2 ? 8'h82 : 8'h86);
      repeat (3) @(posedge clk);
      chk("stall", 64'h0, stall);
      bus(1'b0, spfs_pkg::CTRL_OFS, 8'h00, q);
      chk("ctrl_go_abort", 64'h1, {q[1], q[3]});
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_erase;
    logic [31:0] q;
    setptr(22'h000047);
    wrr(spfs_pkg::CTRL_OFS, 8'h94);
    for (int i = 0; i < 128; i++) snap[i] = u_flash.mem[i];
    go(8'h96);
    wait_done();
    bus(1'b0, spfs_pkg::CTRL_OFS, 8'h00, q);
    chk("ctrl", 64'h84, q[7:0]);
    for (int i = 0; i < 128; i++) chk("erase_word", i / 32 == 1 ? 16'hFFFF : snap[i], u_flash.mem[i]);
    $display("test erase done");
  endtask : t_erase
  task automatic t_program;
    logic [7:0] d [8];
    for (int k = 0; k < 8; k++) d[k] = 8'hFF;
    d[0] = 8'h0F;
    d[1] = 8'hF0;
    d[5] = 8'h00;
    for (int i = 0; i < 128; i++) snap[i] = u_flash.mem[i];
    setptr(22'h000010);
    for (int k = 0; k < 8; k++) begin
      if (d[k] != 8'hFF) begin
        wrr(spfs_pkg::PTR_LOW_OFS, {5'b00010, k[2:0]});
        wrr(spfs_pkg::LATCH_OFS, d[k]);
        wrr(spfs_pkg::TABLE_OP_OFS, 8'h01);
      end
    end
    wrr(spfs_pkg::CTRL_OFS, 8'h84);
    go(8'h86);
    wait_done();
    for (int j = 0; j < 4; j++) chk("prog_word", snap[8+j] & {d[2*j+1], d[2*j]}, u_flash.mem[8+j]);
    chk("neighbours", {snap[7], snap[12]}, {u_flash.mem[7], u_flash.mem[12]});
    for (int i = 0; i < 128; i++) snap[i] = u_flash.mem[i];
    go(8'h86);
    wait_done();
    chk("hold_default", 64'hFFFFFFFFFFFFFFFF, fblock);
    for (int j = 0; j < 4; j++) chk("reprog_word", snap[8+j], u_flash.mem[8+j]);
    $display("test program done");
  endtask : t_program
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_read();
    t_refuse();
    t_erase();
    t_program();
    summarize();
  end
endmodule : spfs_sequencer_tb_top
`default_nettype wire
